// File: crc8_tree.v
`timescale 1ns/1ps
`include "write_crc_consts.vh"
module crc8_tree (
  // Codeword in
  input  wire [71:0] data_i,
  // Checksum out
  output reg  [7:0]  crc_o
);

  integer i;
  reg     fb;

  // Serial form of the tree, bit 0 first; synthesis flattens it
  always @* begin
    crc_o = `CRC_INIT;
    fb    = 1'b0;
    for (i = 0; i < `TREE_BITS; i = i + 1) begin
      fb    = crc_o[7] ^ data_i[i];
      crc_o = {crc_o[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
    end
  end

endmodule // crc8_tree

// File: crc_frame_checker.sv
`timescale 1ns/1ps
module crc_frame_checker (
  // Clock and reset
  input wire        clk_i,
  input wire        reset_i,
  // Register port
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  // Frame side
  input wire        wr_start_i,
  input wire        dqs_i,
  input wire        alert_o,
  input wire        alert_oe_o,
  input wire        frame_done_o,
  input wire        frame_ok_o,
  input wire        irq_o
);
  reg [3:0] tog;
  reg       dqs_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Raw strobe transitions since the last command; frames are always even
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tog   <= 4'h0;
      dqs_q <= 1'b0;
    end else begin
      dqs_q <= dqs_i;
      if (wr_start_i)
        tog <= 4'h0;
      else if (dqs_i != dqs_q)
        tog <= tog + 4'h1;
    end
  end
  // Open-drain pin only ever pulls low
  AST_ALERT_LOW: assert property (alert_o == 1'b0)
    else $error("alert level not low");
  AST_ALERT_PW: assert property ($rose(alert_oe_o) |-> alert_oe_o[*6] ##1 !alert_oe_o)
    else $error("alert pulse not six clocks");
  AST_ALERT_AT_DONE: assert property ($rose(alert_oe_o) |-> frame_done_o && !frame_ok_o)
    else $error("alert without failed frame");
  AST_OK_NO_ALERT: assert property (frame_done_o && frame_ok_o |-> !alert_oe_o)
    else $error("alert on good frame");
  AST_DONE_PULSE: assert property (frame_done_o |=> !frame_done_o)
    else $error("done longer than one clock");
  AST_OK_HOLD: assert property (!frame_done_o |-> $stable(frame_ok_o))
    else $error("frame result moved between frames");
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  AST_FRAME_LEN: assert property (frame_done_o |-> tog == 4'h4 || tog == 4'h8 || tog == 4'hA)
    else $error("frame length not 4, 8 or 10");
  AST_IRQ_CLEAR: assert property (wr_i && addr_i == 8'h0C && wdata_i == 32'h7 |-> ##[1:3] !irq_o)
    else $error("interrupt not cleared");
  // Main scenarios reached
  cover property (frame_done_o && frame_ok_o);
  cover property ($rose(alert_oe_o));
  cover property ($rose(irq_o));
endmodule // crc_frame_checker
bind write_crc_bc4_frame_mapper crc_frame_checker i_crc_frame_checker (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .wr_start_i(wr_start_i), .dqs_i(dqs_i),
  .alert_o(alert_o), .alert_oe_o(alert_oe_o), .frame_done_o(frame_done_o),
  .frame_ok_o(frame_ok_o), .irq_o(irq_o));

// File: link_sync.v
`timescale 1ns/1ps
module link_sync #(
  parameter W = 10
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         reset_i,
  // Pins in, resynchronised out
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);

  reg [W-1:0] meta;

  // Two stages; strobe and data take the same path so they stay aligned
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta   <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // link_sync

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg  [7:0]  addr_i = 8'h00;
  reg  [31:0] wdata_i = 32'h0;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg         wr_start_i = 1'b0;
  reg         bc4_i = 1'b0;
  reg         a2_i = 1'b0;
  reg         go = 1'b0;
  reg  [3:0]  nbeats = 4'h0;
  reg  [89:0] beats = 90'h0;
  reg  [7:0]  last_crc = 8'h00;
  wire        dqs_i, dm_i, alert_o, alert_oe_o, frame_done_o, frame_ok_o, irq_o;
  wire [7:0]  dq_i;
  wire [31:0] rdata_o;
  integer     num_errors = 0;
  integer     comparisons = 0;

  always #4 clk_i = ~clk_i;

  write_crc_bc4_frame_mapper i_write_crc_bc4_frame_mapper (.clk_i(clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .wr_start_i(wr_start_i), .bc4_i(bc4_i), .a2_i(a2_i),
    .dqs_i(dqs_i), .dq_i(dq_i), .dm_i(dm_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
    .frame_done_o(frame_done_o), .frame_ok_o(frame_ok_o), .irq_o(irq_o));
  wr_ctrl_model i_wr_ctrl_model (.clk_i(clk_i), .go_i(go), .nbeats_i(nbeats),
    .beats_i(beats), .dqs_o(dqs_i), .dq_o(dq_i), .dm_o(dm_i));

  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      // One edge passes so a following strobe is not driven twice at once
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e, "rdata");
      @(posedge clk_i);
    end
  endtask
  // Build a frame, send it, judge the result; bad 1 spoils checksum, 2 the pad
  task frm(input [5:0] ctl, input b4, input a2, input [1:0] bad, input ok);
    reg [8:0]  bt [0:9];
    reg [71:0] tr;
    reg [7:0]  c;
    integer    nd, b, l;
    begin
      nd = (ctl[1] ? b4 : ctl[2]) ? 4 : 8;
      for (b = 0; b < 10; b = b + 1)
        bt[b] = (b < nd) ? 9'(9'h1A5 ^ (b * 75) ^ ctl) : 9'h1FF;
      tr = {72{1'b1}};
      for (l = 0; l < 8; l = l + 1)
        for (b = 0; b < nd; b = b + 1)
          if (!ctl[3] || l < 4) tr[l*8+b] = bt[b][l];
      for (b = 0; b < nd; b = b + 1)
        if (!ctl[3] && (ctl[4] || ctl[5])) tr[((nd == 4 && a2) ? 68 : 64) + b] = bt[b][8];
      c = 8'h00;
      for (b = 0; b < 72; b = b + 1)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ tr[b]) ? 8'h07 : 8'h00);
      if (ctl[3]) begin
        bt[8][3:0] = c[3:0];
        bt[9][3:0] = c[7:4];
      end else
        bt[8][7:0] = c;
      bt[8][0] = bt[8][0] ^ (bad == 2'd1);
      bt[9][7] = (bad != 2'd2);
      last_crc = c;
      for (b = 0; b < 10; b = b + 1)
        beats[b*9 +: 9] = bt[b];
      nbeats = ctl[0] ? 4'hA : 4'(nd);
      wr(8'h00, {26'h0, ctl});
      wr_start_i <= 1'b1;
      bc4_i <= b4;
      a2_i <= a2;
      go <= 1'b1;
      @(posedge clk_i);
      wr_start_i <= 1'b0;
      go <= 1'b0;
      for (b = 0; b < 200 && frame_done_o !== 1'b1; b = b + 1) begin
        @(posedge clk_i);
        #1;
      end
      chk(frame_done_o, 1'b1, "frame_done");
      chk(frame_ok_o, ok, "frame_ok");
      chk(alert_oe_o, bad == 2'd1 && ctl[0], "alert_oe");
      repeat (6) @(posedge clk_i);
    end
  endtask
  task test_done;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Watchdog against a hung frame
  initial begin
    #100000;
    num_errors = num_errors + 1;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h1C, 32'h0);
    frm(6'h15, 1'b0, 1'b0, 2'd0, 1'b1);
    rd(8'h10, {16'h0, last_crc, last_crc});
    frm(6'h13, 1'b1, 1'b1, 2'd0, 1'b1);
    frm(6'h25, 1'b0, 1'b1, 2'd0, 1'b1);
    frm(6'h05, 1'b0, 1'b0, 2'd0, 1'b1);
    frm(6'h0D, 1'b0, 1'b1, 2'd0, 1'b1);
    frm(6'h03, 1'b0, 1'b0, 2'd0, 1'b1);
    wr(8'h08, 32'h2);
    rd(8'h08, 32'h2);
    frm(6'h05, 1'b0, 1'b0, 2'd1, 1'b0);
    #1 chk(irq_o, 1'b1, "irq");
    @(posedge clk_i);
    rd(8'h04, 32'h3);
    wr(8'h0C, 32'h7);
    repeat (2) @(posedge clk_i);
    #1 chk(irq_o, 1'b0, "irq");
    @(posedge clk_i);
    frm(6'h05, 1'b0, 1'b0, 2'd2, 1'b0);
    rd(8'h04, 32'h5);
    #1 chk(irq_o, 1'b0, "irq");
    @(posedge clk_i);
    frm(6'h04, 1'b0, 1'b0, 2'd1, 1'b1);
    rd(8'h14, 32'h1);
    test_done;
  end
endmodule // testbench

// File: wr_ctrl_model.sv
`timescale 1ns/1ps
module wr_ctrl_model (
  // Clock and frame request
  input  wire        clk_i,
  input  wire        go_i,
  input  wire [3:0]  nbeats_i,
  input  wire [89:0] beats_i,
  // Data pins
  output reg         dqs_o = 1'b0,
  output reg  [7:0]  dq_o = 8'h00,
  output reg         dm_o = 1'b0
);
  integer i;
  // Strobe period 125 ns, free of the clock; data moves midway between
  // transitions so the receiver sees it settled; strobe still between frames
  always @(posedge clk_i) begin
    if (go_i) begin
      for (i = 0; i < nbeats_i; i = i + 1) begin
        {dm_o, dq_o} <= beats_i[i*9 +: 9];
        #31.25;
        dqs_o <= ~dqs_o;
        #31.25;
      end
      {dm_o, dq_o} <= ~beats_i[(nbeats_i-1)*9 +: 9]; // Released: inverse of last beat
    end
  end
endmodule // wr_ctrl_model

// File: write_crc_bc4_frame_mapper.v
// Behaviour
// - Chopped four-beat writes are checked as well as full eight-beat writes.
// - Checking is switched by a control bit; only writes while on are checked.
// - With checking on every write frame is exactly ten unit intervals.
// - Burst chop may be chosen per write command when on-the-fly is enabled.
// - Narrow device, chopped write: sixteen data bits feed the tree, rest ones.
// - Upper-half column: beats carry upper nibbles, placed at lower nibble positions.
// - Wide device, chopped write: 32 data bits from beats 0-3, beats 4-7 ones.
// - Lower half: mask lane feeds inputs 67..64 if mask or inversion, else ones.
// - Upper half: mask lane feeds inputs 71..68 if mask or inversion, else ones.
// - Checksum of received codeword compared with received one; mismatch drives alert.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "write_crc_consts.vh"
module write_crc_bc4_frame_mapper (
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // Write command from the command decoder
  input  wire        wr_start_i,
  input  wire        bc4_i,
  input  wire        a2_i,
  // Data pins
  input  wire        dqs_i,
  input  wire [7:0]  dq_i,
  input  wire        dm_i,
  // Alert pin, open drain
  output reg         alert_o,
  output reg         alert_oe_o,
  // Frame results and interrupt
  output reg         frame_done_o,
  output reg         frame_ok_o,
  output reg         irq_o
);

  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_RECV  = 3'b010;
  localparam [2:0] S_CHECK = 3'b100;

  reg  [2:0]              state;
  reg  [`CTRL_WIDTH-1:0]  ctrl;
  reg  [`ST_WIDTH-1:0]    status;
  reg  [`ST_WIDTH-1:0]    irq_en;
  reg  [`ST_WIDTH-1:0]    next_status;
  reg  [`ST_WIDTH-1:0]    st_set;
  reg  [7:0]              crc_calc;
  reg  [7:0]              crc_recv;
  reg  [15:0]             err_count;
  reg  [3:0]              ui_cnt;
  reg  [3:0]              ui_len;
  reg  [2:0]              alert_cnt;
  reg                     dqs_prev;
  reg                     f_bc4;
  reg                     f_a2;
  reg                     f_crc;
  reg                     f_x4;
  reg                     f_mask;
  reg                     f_inv;
  reg  [8:0]              beat [0:9];
  reg  [71:0]             tree;
  reg  [7:0]              rx_crc;
  reg                     pad_bad;
  wire [9:0]              pins_s;
  wire [7:0]              crc_w;
  wire                    dqs_s;
  wire                    edge_s;
  wire                    cmd_bc4;
  integer                 b;
  integer                 l;
  integer                 p;
  integer                 k;

  // Strobe, mask lane and data lanes resynchronised together
  link_sync #(.W(10)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({dqs_i, dm_i, dq_i}),
    .sync_o  (pins_s)
  );

  crc8_tree u_tree (
    .data_i (tree),
    .crc_o  (crc_w)
  );

  assign dqs_s  = pins_s[9];
  assign edge_s = dqs_s ^ dqs_prev;  // Each strobe transition is one UI

  // Per-command chop only when on-the-fly selection is enabled
  assign cmd_bc4 = ctrl[`CTRL_OTF_EN] ? bc4_i : ctrl[`CTRL_BC4_FIXED];

  // Frame length fixed at ten UI whenever checking is on
  always @* begin
    if (ctrl[`CTRL_CRC_EN]) begin
      ui_len = `UI_CRC_FRAME;
    end else if (cmd_bc4) begin
      ui_len = `UI_BC4;
    end else begin
      ui_len = `UI_BL8;
    end
  end

  // Tree input assembly; unused positions stay at one
  always @* begin
    tree = {`TREE_BITS{1'b1}};
    for (b = 0; b < 8; b = b + 1) begin
      for (l = 0; l < `LANES; l = l + 1) begin
        // Chopped writes: beats 4-7 count as ones in the tree
        if ((b < `BC4_BEATS || !f_bc4) && (l < 4 || !f_x4)) begin
          // Upper half arrives in beats 0-3 and lands on low nibble slots
          tree[l*8+b] = beat[b][l];
        end
      end
      // Mask lane used only on the wide device with mask or inversion on
      if (!f_x4 && f_mask) begin
        if (!f_bc4) begin
          tree[`MASK_LO_BASE+b] = beat[b][8];
        end else if (b < `BC4_BEATS) begin
          if (f_a2) begin
            tree[`MASK_HI_BASE+b] = beat[b][8];
          end else begin
            tree[`MASK_LO_BASE+b] = beat[b][8];
          end
        end
      end
    end
  end

  // Received checksum and pad check of the controller's fill bits
  always @* begin
    pad_bad = 1'b0;
    if (f_x4) begin
      rx_crc = {beat[9][3:0], beat[8][3:0]};
    end else begin
      rx_crc = beat[8][7:0];
      if (beat[9][7:0] != 8'hFF) begin
        pad_bad = 1'b1;
      end
      if (f_inv && (!beat[8][8] || !beat[9][8])) begin
        pad_bad = 1'b1;
      end
    end
    if (f_bc4) begin
      for (p = `BC4_BEATS; p < 8; p = p + 1) begin
        if (f_x4 ? (beat[p][3:0] != 4'hF) : (beat[p][7:0] != 8'hFF)) begin
          pad_bad = 1'b1;
        end
      end
    end
  end

  // Frame capture and check sequence
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state        <= S_IDLE;
      dqs_prev     <= 1'b0;
      ui_cnt       <= 4'h0;
      f_bc4        <= 1'b0;
      f_a2         <= 1'b0;
      f_crc        <= 1'b0;
      f_x4         <= 1'b0;
      f_mask       <= 1'b0;
      f_inv        <= 1'b0;
      crc_calc     <= 8'h00;
      crc_recv     <= 8'h00;
      frame_done_o <= 1'b0;
      frame_ok_o   <= 1'b0;
      for (k = 0; k < 10; k = k + 1) begin
        beat[k] <= 9'h1FF;
      end
    end else begin
      dqs_prev     <= dqs_s;
      frame_done_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (wr_start_i) begin
            // Settings are frozen per frame so a mid-frame write cannot tear it
            f_bc4  <= cmd_bc4;
            f_a2   <= a2_i;
            f_crc  <= ctrl[`CTRL_CRC_EN];
            f_x4   <= ctrl[`CTRL_X4];
            f_mask <= ctrl[`CTRL_MASK_EN] | ctrl[`CTRL_INV_EN];
            f_inv  <= ctrl[`CTRL_INV_EN];
            ui_cnt <= ui_len - 4'h1;
            for (k = 0; k < 10; k = k + 1) begin
              beat[k] <= 9'h1FF;
            end
            state  <= S_RECV;
          end
        end
        S_RECV: begin
          if (edge_s) begin
            beat[`UI_CRC_FRAME-4'h1-ui_cnt] <= pins_s[8:0];
            if (ui_cnt == 4'h0) begin
              state <= S_CHECK;
            end else begin
              ui_cnt <= ui_cnt - 4'h1;
            end
          end
        end
        S_CHECK: begin
          crc_calc     <= crc_w;
          crc_recv     <= rx_crc;
          frame_done_o <= 1'b1;
          frame_ok_o   <= !f_crc || (crc_w == rx_crc && !pad_bad);
          state        <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Events raised by the check step
  always @* begin
    st_set = {`ST_WIDTH{1'b0}};
    if (state == S_CHECK) begin
      st_set[`ST_DONE] = 1'b1;
      if (f_crc) begin
        st_set[`ST_CRC_ERR] = (crc_w != rx_crc);
        st_set[`ST_PAD_ERR] = pad_bad;
      end
    end
  end

  // Sticky status: a set in the same cycle as its clear wins
  always @* begin
    next_status = status;
    if (wr_i && addr_i == `REG_IRQ_CLR) begin
      next_status = status & ~wdata_i[`ST_WIDTH-1:0];
    end
    next_status = next_status | st_set;
  end

  // Registers, interrupt and alert pulse
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl       <= `CTRL_RESET;
      irq_en     <= `ST_RESET;
      status     <= `ST_RESET;
      err_count  <= 16'h0000;
      alert_cnt  <= 3'h0;
      alert_o    <= 1'b0;
      alert_oe_o <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      status <= next_status;
      irq_o  <= |(next_status & irq_en);
      if (wr_i && addr_i == `REG_CTRL) begin
        ctrl <= wdata_i[`CTRL_WIDTH-1:0];
      end
      if (wr_i && addr_i == `REG_IRQ_EN) begin
        irq_en <= wdata_i[`ST_WIDTH-1:0];
      end
      // Mismatch pulls the shared alert line low for a fixed width
      if (st_set[`ST_CRC_ERR]) begin
        alert_cnt  <= `ALERT_PW_CYC;
        alert_oe_o <= 1'b1;
        if (err_count != 16'hFFFF) begin
          err_count <= err_count + 16'h0001;  // Saturates rather than wraps
        end
      end else if (alert_cnt != 3'h0) begin
        alert_cnt  <= alert_cnt - 3'h1;
        alert_oe_o <= (alert_cnt != 3'h1);
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `REG_CTRL:      rdata_o <= {26'h0, ctrl};
        `REG_STATUS:    rdata_o <= {29'h0, status};
        `REG_IRQ_EN:    rdata_o <= {29'h0, irq_en};
        `REG_CRC_SEEN:  rdata_o <= {16'h0000, crc_recv, crc_calc};
        `REG_ERR_COUNT: rdata_o <= {16'h0000, err_count};
        default:        rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

endmodule // write_crc_bc4_frame_mapper

// File: write_crc_consts.vh
`ifndef WRITE_CRC_CONSTS_VH
`define WRITE_CRC_CONSTS_VH

// Register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_EN      8'h08
`define REG_IRQ_CLR     8'h0C
`define REG_CRC_SEEN    8'h10
`define REG_ERR_COUNT   8'h14

// Control field positions
`define CTRL_CRC_EN     0
`define CTRL_OTF_EN     1
`define CTRL_BC4_FIXED  2
`define CTRL_X4         3
`define CTRL_MASK_EN    4
`define CTRL_INV_EN     5
`define CTRL_WIDTH      6
`define CTRL_RESET      6'h00

// Status, enable and clear share this layout
`define ST_DONE         0
`define ST_CRC_ERR      1
`define ST_PAD_ERR      2
`define ST_WIDTH        3
`define ST_RESET        3'h0

// Frame geometry in unit intervals
`define UI_CRC_FRAME    4'hA
`define UI_BL8          4'h8
`define UI_BC4          4'h4
`define BC4_BEATS       4
`define LANES           8
`define MASK_LO_BASE    64
`define MASK_HI_BASE    68
`define TREE_BITS       72

// Checksum polynomial x^8+x^2+x+1, low terms
`define CRC_POLY        8'h07
`define CRC_INIT        8'h00

// Alert pulse width in device clocks
`define ALERT_PW_CYC    3'h6

`endif
